// ==== hdl/ampdc_link_port.sv ====
// link-clock side of the register access handshake
`timescale 1ns/10ps
module ampdc_link_port
    import ampdc_pkg::*;
(
    // link clock and reset
    input logic link_clk,
    input logic arst_n,
    // host side
    input logic lnk_req,
    input ampdc_req_t lnk_cmd,
    output logic lnk_busy,
    output logic lnk_done,
    output logic [7:0] lnk_rdata,
    // toward the system domain
    output logic req_tgl,
    output ampdc_req_t cmd_hold,
    input logic ack_tgl,
    input logic [7:0] sys_rdata
);
    // ack toggle synchroniser, third stage for edge
    logic ack_s1, ack_s2, ack_s3;
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end
    // take a request only when idle; held stable until ack
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_hold <= '0;
            req_tgl <= 1'b0;
            lnk_busy <= 1'b0;
            lnk_done <= 1'b0;
            lnk_rdata <= 8'h00;
        end else begin
            lnk_done <= 1'b0;
            if (lnk_busy && (ack_s2 ^ ack_s3)) begin
                // sys_rdata is stable since the ack toggled
                lnk_busy <= 1'b0;
                lnk_done <= 1'b1;
                lnk_rdata <= sys_rdata;
            end else if (lnk_req && !lnk_busy) begin
                cmd_hold <= lnk_cmd;
                req_tgl <= ~req_tgl;
                lnk_busy <= 1'b1;
            end
        end
    end
endmodule

// ==== hdl/ampdc_pkg.sv ====
// package for the amplifier diagnostic and clip register bank
package ampdc_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_AC1 = 8'h15;
    localparam logic [7:0] ADDR_AC2 = 8'h16;
    localparam logic [7:0] ADDR_IMP = 8'h17;
    localparam logic [7:0] ADDR_PHH = 8'h1B;
    localparam logic [7:0] ADDR_PHL = 8'h1C;
    localparam logic [7:0] ADDR_AUH = 8'h1D;
    localparam logic [7:0] ADDR_AUL = 8'h1E;
    localparam logic [7:0] ADDR_MISC3 = 8'h21;
    localparam logic [7:0] ADDR_CLIPC = 8'h22;
    localparam logic [7:0] ADDR_CLIPT = 8'h23;
    localparam logic [7:0] ADDR_CLIPS = 8'h24;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_GAIN = 7;
    localparam int BIT_RUN = 3;
    localparam int BIT_LOOP = 7;
    localparam int BIT_LEN = 4;
    localparam int BIT_CUR_HI = 3;
    localparam int BIT_CUR_LO = 2;
    localparam int BIT_FCLR = 7;
    localparam int BIT_TDM = 6;
    localparam int BIT_ILMASK = 5;
    localparam int BIT_OTAUTO = 3;
    localparam int BIT_CROUTE = 2;
    localparam int BIT_CHOLD = 1;
    localparam int BIT_CEN = 0;
    localparam int BIT_CFLAG = 0;
    // ----------------------------------------
    // reset values and writable masks
    // ----------------------------------------
    localparam logic [7:0] RST_AC1 = 8'h00;
    localparam logic [7:0] RST_AC2 = 8'h00;
    localparam logic [7:0] RST_MISC3 = 8'h00;
    localparam logic [7:0] RST_CLIPC = 8'h01;
    localparam logic [7:0] RST_CLIPT = 8'h14;
    localparam logic [7:0] RST_RES = 8'h00;
    localparam logic [7:0] MASK_AC1 = 8'h88;
    localparam logic [7:0] MASK_AC2 = 8'h9C;
    localparam logic [7:0] MASK_MISC3 = 8'h68;
    localparam logic [7:0] MASK_CLIPC = 8'h07;
    // ----------------------------------------
    // measurement lengths in cycles
    // ----------------------------------------
    localparam logic [6:0] MEAS_SHORT = 7'h20;
    localparam logic [6:0] MEAS_LONG = 7'h40;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } ampdc_req_t;
    typedef struct packed {
        logic [7:0] imp;
        logic [15:0] phase;
        logic [15:0] aux;
    } ampdc_res_t;
endpackage

// ==== hdl/ampdc_regs.sv ====
// register bank for load diagnostics, misc control and clip detection
`timescale 1ns/10ps
module ampdc_regs
    import ampdc_pkg::*;
#(
    parameter int THR_W = 8 // clip counter width
)(
    // system clock and reset
    input logic sys_clk,
    input logic arst_n,
    // link side register access
    input logic link_clk,
    input logic lnk_req,
    input ampdc_req_t lnk_cmd,
    output logic lnk_busy,
    output logic lnk_done,
    output logic [7:0] lnk_rdata,
    // measurement engine
    input logic diag_done,
    input ampdc_res_t diag_res,
    output logic ac_diag_run,
    output logic ac_diag_gain_sel,
    output logic ac_return_path_en,
    output logic [6:0] ac_measure_length,
    output logic [1:0] ac_test_current_sel,
    // modulator and protection
    input logic pwm_cycle,
    input logic pwm_full_duty,
    input logic current_limit_event,
    input logic overtemp_shutdown,
    output logic ot_shutdown_hold,
    output logic tdm_slot_16,
    output logic fault_clear_pulse,
    // pins
    output logic warn_out,
    output logic fault_out,
    output logic clip_seen_flag
);
    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (THR_W != 8) begin : g_bad_width
        // threshold register is one byte wide
        $error("ampdc_regs: THR_W must be 8");
    end

    // ----------------------------------------
    // clock crossing
    // ----------------------------------------
    logic req_tgl; // request toggle, link domain
    ampdc_req_t cmd_hold; // held command, stable while busy
    logic ack_tgl_r; // ack toggle, system domain
    logic [7:0] rdata_r; // read answer, stable for link
    logic req_s1, req_s2, req_s3; // toggle synchroniser
    logic fire; // one-cycle access strobe
    logic wr_fire, rd_fire;

    ampdc_link_port u_link (
        .link_clk(link_clk),
        .arst_n(arst_n),
        .lnk_req(lnk_req),
        .lnk_cmd(lnk_cmd),
        .lnk_busy(lnk_busy),
        .lnk_done(lnk_done),
        .lnk_rdata(lnk_rdata),
        .req_tgl(req_tgl),
        .cmd_hold(cmd_hold),
        .ack_tgl(ack_tgl_r),
        .sys_rdata(rdata_r)
    );

    // synchronise the request toggle; first stage feeds only the second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    // command fields settled long before the toggle arrives
    assign fire = req_s2 ^ req_s3;
    assign wr_fire = fire && cmd_hold.wr;
    assign rd_fire = fire && !cmd_hold.wr;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic [7:0] ac1_r, ac2_r, misc3_r, clipc_r, clipt_r;
    logic [7:0] imp_r; // impedance code
    logic [15:0] phase_r; // phase result
    logic [15:0] aux_r; // auxiliary result

    // masked write helper: reserved bits stay zero
    function automatic logic [7:0] mwr(input logic [7:0] d, input logic [7:0] m);
        mwr = d & m;
    endfunction

    // control registers written over the link
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ac1_r <= RST_AC1;
            ac2_r <= RST_AC2;
            misc3_r <= RST_MISC3;
            clipc_r <= RST_CLIPC;
            clipt_r <= RST_CLIPT;
        end else if (wr_fire) begin
            if (cmd_hold.addr == ADDR_AC1) begin
                ac1_r <= mwr(cmd_hold.data, MASK_AC1);
            end else if (cmd_hold.addr == ADDR_AC2) begin
                ac2_r <= mwr(cmd_hold.data, MASK_AC2);
            end else if (cmd_hold.addr == ADDR_MISC3) begin
                // clear bit is not stored: it acts once per write
                misc3_r <= mwr(cmd_hold.data, MASK_MISC3);
            end else if (cmd_hold.addr == ADDR_CLIPC) begin
                clipc_r <= mwr(cmd_hold.data, MASK_CLIPC);
            end else if (cmd_hold.addr == ADDR_CLIPT) begin
                // zero is the host's mistake; it acts as a threshold of one
                clipt_r <= cmd_hold.data;
            end
        end
    end

    // result registers captured when the engine finishes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            imp_r <= RST_RES;
            phase_r <= {RST_RES, RST_RES};
            aux_r <= {RST_RES, RST_RES};
        end else if (diag_done) begin
            imp_r <= diag_res.imp;
            phase_r <= diag_res.phase;
            aux_r <= diag_res.aux;
        end
    end

    // ----------------------------------------
    // read decode and answer
    // ----------------------------------------
    // unmapped addresses answer zero
    function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] clip_s);
        if (a == ADDR_AC1) begin
            rd_mux = ac1_r;
        end else if (a == ADDR_AC2) begin
            rd_mux = ac2_r;
        end else if (a == ADDR_IMP) begin
            rd_mux = imp_r;
        end else if (a == ADDR_PHH) begin
            rd_mux = phase_r[15:8];
        end else if (a == ADDR_PHL) begin
            rd_mux = phase_r[7:0];
        end else if (a == ADDR_AUH) begin
            rd_mux = aux_r[15:8];
        end else if (a == ADDR_AUL) begin
            rd_mux = aux_r[7:0];
        end else if (a == ADDR_MISC3) begin
            rd_mux = misc3_r;
        end else if (a == ADDR_CLIPC) begin
            rd_mux = clipc_r;
        end else if (a == ADDR_CLIPT) begin
            rd_mux = clipt_r;
        end else if (a == ADDR_CLIPS) begin
            rd_mux = clip_s;
        end else begin
            rd_mux = 8'h00;
        end
    endfunction

    // answer one cycle after the strobe, ack toggled on the same edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
            ack_tgl_r <= 1'b0;
        end else if (fire) begin
            // writes answer zero; reads carry the byte
            rdata_r <= rd_fire ? rd_mux(cmd_hold.addr, {7'h00, clip_seen_flag}) : 8'h00;
            ack_tgl_r <= ~ack_tgl_r;
        end
    end

    // ----------------------------------------
    // engine controls
    // ----------------------------------------
    // outputs come straight from flops; length lags its bit by a cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ac_measure_length <= MEAS_SHORT;
        end else begin
            ac_measure_length <= ac2_r[BIT_LEN] ? MEAS_LONG : MEAS_SHORT;
        end
    end
    assign ac_diag_run = ac1_r[BIT_RUN];
    assign ac_diag_gain_sel = ac1_r[BIT_GAIN];
    assign ac_return_path_en = ac2_r[BIT_LOOP];
    assign ac_test_current_sel = ac2_r[BIT_CUR_HI:BIT_CUR_LO];
    assign tdm_slot_16 = misc3_r[BIT_TDM];

    // ----------------------------------------
    // fault clear
    // ----------------------------------------
    // one pulse per written one; zero leaves things running
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_clear_pulse <= 1'b0;
        end else begin
            fault_clear_pulse <= wr_fire && (cmd_hold.addr == ADDR_MISC3) && cmd_hold.data[BIT_FCLR];
        end
    end

    // ----------------------------------------
    // overtemperature shutdown hold
    // ----------------------------------------
    // latched mode keeps shutdown until a clear; a live event wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ot_shutdown_hold <= 1'b0;
        end else if (overtemp_shutdown) begin
            ot_shutdown_hold <= 1'b1;
        end else if (misc3_r[BIT_OTAUTO] || fault_clear_pulse) begin
            ot_shutdown_hold <= 1'b0;
        end
    end

    // ----------------------------------------
    // clip detection
    // ----------------------------------------
    logic [THR_W-1:0] run_r; // consecutive full-duty cycles
    logic [THR_W-1:0] run_nxt;
    logic clip_en, clip_hold_off, clip_hit;
    assign clip_en = clipc_r[BIT_CEN];
    assign clip_hold_off = clipc_r[BIT_CHOLD];
    // saturate so a long clip never wraps back below the threshold
    assign run_nxt = (run_r == {THR_W{1'b1}}) ? run_r : run_r + 1'b1;
    assign clip_hit = clip_en && pwm_cycle && pwm_full_duty && (run_nxt >= clipt_r);

    // count consecutive full-duty cycles, reset on any gap
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= '0;
        end else if (!clip_en) begin
            run_r <= '0;
        end else if (pwm_cycle) begin
            run_r <= pwm_full_duty ? run_nxt : '0;
        end
    end

    // status flag: latching holds until cleared, set wins over clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clip_seen_flag <= 1'b0;
        end else if (!clip_en) begin
            clip_seen_flag <= 1'b0;
        end else if (clip_hold_off) begin
            // non-latching: follows each cycle, threshold unused
            if (pwm_cycle) begin
                clip_seen_flag <= pwm_full_duty;
            end
        end else if (clip_hit) begin
            clip_seen_flag <= 1'b1;
        end else if (fault_clear_pulse) begin
            clip_seen_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // warn and fault pins
    // ----------------------------------------
    // pins are active high here; the pad inverts if needed
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            warn_out <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            warn_out <= (current_limit_event && !misc3_r[BIT_ILMASK]) ||
                (clip_seen_flag && !clipc_r[BIT_CROUTE]);
            fault_out <= ot_shutdown_hold || (clip_seen_flag && clipc_r[BIT_CROUTE]);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_wr(logic [7:0] a);
        wr_fire && cmd_hold.addr == a;
    endsequence
    sequence s_clr_wr;
        s_wr(ADDR_MISC3) ##0 cmd_hold.data[BIT_FCLR];
    endsequence
    sequence s_clr_pulse;
        fault_clear_pulse ##1 !fault_clear_pulse;
    endsequence

    a_loopback_write: assert property (s_wr(ADDR_AC2) |=> ac_return_path_en == $past(cmd_hold.data[BIT_LOOP]))
        else $error("loopback bit not taken");
    a_measure_len: assert property (s_wr(ADDR_AC2) |=> ##1 ac_measure_length ==
        ($past(cmd_hold.data[BIT_LEN], 2) ? MEAS_LONG : MEAS_SHORT))
        else $error("measure length wrong");
    a_current_write: assert property (s_wr(ADDR_AC2) |=> ac_test_current_sel == $past(cmd_hold.data[3:2]))
        else $error("test current not taken");
    a_imp_capture: assert property (diag_done
        |=> imp_r == $past(diag_res.imp))
        else $error("impedance not captured");
    a_phase_read: assert property (rd_fire && cmd_hold.addr == ADDR_PHH |=> rdata_r == $past(phase_r[15:8]))
        else $error("phase high read wrong");
    a_aux_read: assert property (rd_fire && cmd_hold.addr == ADDR_AUL |=> rdata_r == $past(aux_r[7:0]))
        else $error("aux low read wrong");
    a_clear_once: assert property (s_clr_wr |=> s_clr_pulse)
        else $error("fault clear not one pulse");
    a_tdm_write: assert property (s_wr(ADDR_MISC3) |=> tdm_slot_16 == $past(cmd_hold.data[BIT_TDM]))
        else $error("tdm slot bit not taken");
    a_warn_mask: assert property (current_limit_event && !misc3_r[BIT_ILMASK] |=> warn_out)
        else $error("current limit not on warn");
    a_ot_latched: assert property (ot_shutdown_hold && !misc3_r[BIT_OTAUTO] && !fault_clear_pulse
        |=> ot_shutdown_hold)
        else $error("latched shutdown dropped");
    a_clip_route: assert property (clip_seen_flag && clipc_r[BIT_CROUTE] |=> fault_out)
        else $error("clip not routed to fault");
    a_clip_off: assert property (!clip_en |=> !clip_seen_flag && run_r == '0)
        else $error("clip active while disabled");
    a_clip_thresh: assert property ($rose(clip_seen_flag) && !$past(clip_hold_off)
        |-> $past(run_nxt) >= $past(clipt_r))
        else $error("clip before threshold");
    a_status_read: assert property (rd_fire && cmd_hold.addr == ADDR_CLIPS
        |=> rdata_r == {7'h00, $past(clip_seen_flag)})
        else $error("clip status read wrong");
    a_reserved_zero: assert property (rd_fire && cmd_hold.addr == ADDR_AC2 |=> (rdata_r & ~MASK_AC2) == 8'h00)
        else $error("reserved bits not zero");
endmodule

// ==== verif/ampdc_host_model.sv ====
// host-side model issuing register accesses on the link port
`timescale 1ns/10ps
module ampdc_host_model
    import ampdc_pkg::*;
(
    // link clock
    input wire logic link_clk,
    // answers from the device
    input wire logic lnk_done,
    input wire logic [7:0] lnk_rdata,
    // request toward the device
    output logic lnk_req,
    output ampdc_req_t lnk_cmd
);
    // idle until the first access
    initial begin
        lnk_req = 1'b0;
        lnk_cmd = '0;
    end
    // one access; gap idles first, rd stays unknown if no answer comes
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap,
                          output logic [7:0] rd);
        int n;
        n = 0;
        rd = 8'hXX;
        repeat (gap + 1) @(negedge link_clk);
        // a zero threshold is never programmed
        if (wr && a == ADDR_CLIPT && d == 8'h00) d = 8'h01;
        lnk_cmd = '{wr, a, d};
        lnk_req = 1'b1;
        @(negedge link_clk);
        lnk_req = 1'b0;
        // command no longer qualified: show garbage
        lnk_cmd = ~lnk_cmd;
        // result taken only once the access has finished
        while (n < 40) begin
            @(posedge link_clk);
            n++;
            if (lnk_done === 1'b1) begin
                rd = lnk_rdata;
                n = 40;
            end
        end
    endtask
endmodule

// ==== verif/ampdc_regs_test.sv ====
// self-checking testbench for the diagnostic and clip register bank
`timescale 1ns/10ps
module ampdc_regs_test;
    import ampdc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic lnk_req, lnk_busy, lnk_done;
    ampdc_req_t lnk_cmd;
    logic [7:0] lnk_rdata;
    logic diag_done = 1'b0;
    ampdc_res_t diag_res = '0;
    logic ac_diag_run, ac_diag_gain_sel, ac_return_path_en;
    logic [6:0] ac_measure_length;
    logic [1:0] ac_test_current_sel;
    logic pwm_cycle = 1'b0;
    logic pwm_full_duty = 1'b0;
    logic current_limit_event = 1'b0;
    logic overtemp_shutdown = 1'b0;
    logic ot_shutdown_hold, tdm_slot_16, fault_clear_pulse, warn_out, fault_out, clip_seen_flag;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 52739;
    int clr_cnt = 0;
    logic [7:0] shadow [256]; // expected register contents
    localparam logic [7:0] ADDRS [12] = '{ADDR_AC1, ADDR_AC2, ADDR_IMP, ADDR_PHH, ADDR_PHL, ADDR_AUH,
        ADDR_AUL, ADDR_MISC3, ADDR_CLIPC, ADDR_CLIPT, ADDR_CLIPS, 8'h30};
    // ----------------------------------------
    // clocks, design and host
    // ----------------------------------------
    // link clock starts off phase so edges never line up
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    ampdc_regs dut (.sys_clk, .arst_n, .link_clk, .lnk_req, .lnk_cmd, .lnk_busy, .lnk_done, .lnk_rdata,
        .diag_done, .diag_res, .ac_diag_run, .ac_diag_gain_sel, .ac_return_path_en, .ac_measure_length,
        .ac_test_current_sel, .pwm_cycle, .pwm_full_duty, .current_limit_event, .overtemp_shutdown,
        .ot_shutdown_hold, .tdm_slot_16, .fault_clear_pulse, .warn_out, .fault_out, .clip_seen_flag);
    ampdc_host_model host (.link_clk, .lnk_done, .lnk_rdata, .lnk_req, .lnk_cmd);
    // counts clear pulses seen on the system side
    always @(posedge sys_clk) begin
        if (fault_clear_pulse === 1'b1) clr_cnt <= clr_cnt + 1;
    end
    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            ADDR_AC1: return MASK_AC1;
            ADDR_AC2: return MASK_AC2;
            ADDR_MISC3: return MASK_MISC3;
            ADDR_CLIPC: return MASK_CLIPC;
            ADDR_CLIPT: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        chk8(what, {7'h00, e}, {7'h00, g});
    endtask
    // write with random host pacing; write answer is zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        // host never writes a zero threshold nor a reserved current code
        if (a == ADDR_CLIPT && d == 8'h00) d = 8'h01;
        if (a == ADDR_AC2) d[BIT_CUR_HI] = 1'b0;
        host.access(1'b1, a, d, $unsigned($random(seed)) % 3, r);
        shadow[a] = (shadow[a] & ~wmask(a)) | (d & wmask(a));
        chk8("write answer", 8'h00, r);
        // realign to the system clock's falling edge for the next stimulus
        @(negedge sys_clk);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.access(1'b0, a, 8'h00, 0, r);
        chk8(what, e, r);
        chk1("busy after done", 1'b0, lnk_busy);
    endtask
    task automatic out_chk;
        chk1("run", shadow[ADDR_AC1][BIT_RUN], ac_diag_run);
        chk1("gain", shadow[ADDR_AC1][BIT_GAIN], ac_diag_gain_sel);
        chk1("loopback", shadow[ADDR_AC2][BIT_LOOP], ac_return_path_en);
        chk8("current", {6'h00, shadow[ADDR_AC2][3:2]}, {6'h00, ac_test_current_sel});
        chk8("length", shadow[ADDR_AC2][BIT_LEN] ? 8'h40 : 8'h20, {1'b0, ac_measure_length});
        chk1("tdm slot", shadow[ADDR_MISC3][BIT_TDM], tdm_slot_16);
    endtask
    // pwm cycles, full or not, then let the pins settle
    task automatic pwm(input int n, input logic full);
        repeat (n) begin
            @(negedge sys_clk);
            pwm_cycle = 1'b1;
            pwm_full_duty = full;
            @(negedge sys_clk);
            pwm_cycle = 1'b0;
            pwm_full_duty = ~full;
        end
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic settle;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] a;
        logic [31:0] rnd;
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[ADDR_CLIPC] = RST_CLIPC;
        shadow[ADDR_CLIPT] = RST_CLIPT;
        repeat (16) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge link_clk);
        chk8("reset length", 8'h20, {1'b0, ac_measure_length});
        foreach (ADDRS[i]) rd_chk("reset value", ADDRS[i], shadow[ADDRS[i]]);
        // random writes everywhere, read-only and unmapped included
        repeat (24) begin
            a = ADDRS[$unsigned($random(seed)) % 12];
            wr(a, $random(seed));
            rd_chk("readback", a, shadow[a]);
        end
        // current codes 0 and 1 only, every length and control bit both ways
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_AC2, {c[1], 2'b11, c[0], 1'b0, c[0] ^ c[1], 2'b11});
            wr(ADDR_AC1, {c[0], 3'b111, c[1], 3'b111});
            wr(ADDR_MISC3, {1'b0, c[0], 6'h00});
            out_chk();
        end
        // engine results captured only on diag_done
        rnd = $random(seed);
        diag_res = '{8'hFF, rnd[15:0], rnd[31:16]};
        @(negedge sys_clk);
        diag_done = 1'b1;
        @(negedge sys_clk);
        diag_done = 1'b0;
        diag_res = ~diag_res;
        settle();
        wr(ADDR_IMP, 8'h00);
        rd_chk("impedance", ADDR_IMP, 8'hFF);
        rd_chk("phase high", ADDR_PHH, rnd[15:8]);
        rd_chk("phase low", ADDR_PHL, rnd[7:0]);
        rd_chk("aux high", ADDR_AUH, rnd[31:24]);
        rd_chk("aux low", ADDR_AUL, rnd[23:16]);
        // one clear pulse per written one
        clr_cnt = 0;
        wr(ADDR_MISC3, 8'h80);
        settle();
        chk8("clear pulses", 8'h01, clr_cnt[7:0]);
        // latching clip, threshold 5, routed to warn
        wr(ADDR_CLIPT, 8'h05);
        wr(ADDR_CLIPC, 8'h01);
        pwm(4, 1'b1);
        pwm(1, 1'b0);
        pwm(4, 1'b1);
        chk1("clip early", 1'b0, clip_seen_flag);
        pwm(1, 1'b1);
        chk1("clip at threshold", 1'b1, clip_seen_flag);
        chk1("clip warn pin", 1'b1, warn_out);
        rd_chk("clip status", ADDR_CLIPS, 8'h01);
        pwm(2, 1'b0);
        chk1("clip latched", 1'b1, clip_seen_flag);
        wr(ADDR_MISC3, 8'h80);
        settle();
        chk1("clip cleared", 1'b0, clip_seen_flag);
        // non-latching, routed to fault
        wr(ADDR_CLIPC, 8'h07);
        pwm(1, 1'b1);
        chk1("clip follow", 1'b1, clip_seen_flag);
        chk1("clip fault pin", 1'b1, fault_out);
        chk1("clip not warn", 1'b0, warn_out);
        pwm(1, 1'b0);
        chk1("clip drop", 1'b0, clip_seen_flag);
        pwm(1, 1'b1);
        wr(ADDR_CLIPC, 8'h06);
        pwm(3, 1'b1);
        chk1("clip disabled", 1'b0, clip_seen_flag);
        // current limit reported unless masked
        current_limit_event = 1'b1;
        settle();
        chk1("current_limit_event warn", 1'b1, warn_out);
        wr(ADDR_MISC3, 8'h20);
        settle();
        chk1("current_limit_event masked", 1'b0, warn_out);
        current_limit_event = 1'b0;
        // overtemperature latched, then auto recovery
        wr(ADDR_MISC3, 8'h00);
        overtemp_shutdown = 1'b1;
        settle();
        chk1("ot fault pin", 1'b1, fault_out);
        overtemp_shutdown = 1'b0;
        settle();
        chk1("ot latched", 1'b1, ot_shutdown_hold);
        wr(ADDR_MISC3, 8'h80);
        settle();
        chk1("ot cleared", 1'b0, ot_shutdown_hold);
        wr(ADDR_MISC3, 8'h08);
        overtemp_shutdown = 1'b1;
        settle();
        chk1("ot auto set", 1'b1, ot_shutdown_hold);
        overtemp_shutdown = 1'b0;
        settle();
        chk1("ot auto drop", 1'b0, ot_shutdown_hold);
        print_verdict();
    end
    // watchdog well beyond the expected run
    initial begin
        #1000000;
        mismatches++;
        print_verdict();
    end
endmodule
